// ### hdl/sfr_pkg.sv
/*
  Constants for the special-command decoder: command codes, control bit
  positions, reset values and timing counts. Assumes a 25 MHz core clock.
*/
package sfr_pkg;
  localparam int unsigned CLK_MHZ = 25;
  localparam logic [3:0] CMD_NOP = 4'h0;
  localparam logic [3:0] CMD_WRITE_CLEAR_CODE = 4'h1;
  localparam logic [3:0] CMD_SOFT_CLEAR = 4'h2;
  localparam logic [3:0] CMD_POWER_DOWN = 4'h8;
  localparam logic [3:0] CMD_POWER_UP = 4'h9;
  localparam logic [3:0] CMD_MONITOR = 4'hA;
  localparam logic [3:0] CMD_CONTROL_WRITE = 4'hC;
  localparam logic [5:0] CMD_SOFT_RESET = 6'h0F;
  localparam int unsigned CTRL_W = 14;
  localparam int unsigned PD_STATE_BIT = 13;
  localparam int unsigned MON_EN_BIT = 9;
  localparam logic [13:0] CTRL_RESET = 14'h2000;
  localparam logic [13:0] CLEAR_CODE_RESET = 14'h0000;
  localparam logic [5:0] MON_SEL_RESET = 6'h3F;
  localparam logic [5:0] MON_TRISTATE = 6'h3F;
  localparam logic [5:0] MON_EXT_ONE = 6'h24;
  localparam logic [5:0] MON_EXT_TWO = 6'h25;
  localparam int unsigned MON_HI_14 = 13;
  localparam int unsigned MON_HI_12 = 11;
  localparam int unsigned CLEAR_TIME_US_16CH = 20;
  localparam int unsigned CLEAR_TIME_US_8CH = 15;
  localparam int unsigned POWER_UP_TIME_US = 8;
  localparam int unsigned RESET_TIME_US = 135;
  localparam int unsigned CLEAR_CYC_16CH = CLEAR_TIME_US_16CH * CLK_MHZ;
  localparam int unsigned CLEAR_CYC_8CH = CLEAR_TIME_US_8CH * CLK_MHZ;
  localparam int unsigned POWER_UP_CYC = POWER_UP_TIME_US * CLK_MHZ;
  localparam int unsigned RESET_CYC = RESET_TIME_US * CLK_MHZ;
  localparam int unsigned TIMER_W = 12;
endpackage

// ### hdl/busy_timer_if.sv
/*
  Interface between decoder and its busy timer: load strobe with count,
  and the running flag. Assumes one clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
interface busy_timer_if;
  logic load;
  logic [sfr_pkg::TIMER_W-1:0] count;
  logic running;
  modport ctrl (output load, output count, input running);
  modport timer (input load, input count, output running);
endinterface
`default_nettype wire

// ### hdl/busy_timer.sv
/*
  Down counter that stays running for the loaded number of cycles.
  Assumes synchronous active-high reset on core_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module busy_timer (
  input wire logic core_clk,
  input wire logic sys_rst,
  busy_timer_if.timer tif
);
  typedef struct packed {
    logic [sfr_pkg::TIMER_W-1:0] cnt;
  } timer_state_t;
  timer_state_t st_r;
  timer_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (tif.load) begin
      st_nxt.cnt = tif.count;
    end else if (st_r.cnt != '0) begin
      st_nxt.cnt = st_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tif.running = (st_r.cnt != '0);
endmodule
`default_nettype wire

// ### hdl/dac_special_command_decoder.sv
/*
  Decoder for the special-function commands of a multi-channel DAC, taking
  one decoded serial word per strobe. Assumes the serial framing is done
  upstream and that cmd_valid is synchronous to core_clk.
*/
// Operation
// - Both select bits zero picks special commands
// - Code 0010 performs clear with clear code
// - Busy low 20 or 15 us during clear
// - Code 1000 powers down all channels
// - Powered-down output: high impedance or load
// - Control bit 13 picks powered-down output state
// - Registers kept unchanged during power-down; decoder still accepts register writes while powered down
// - Code 1001 powers up within 8 us
// - Power-down is pin OR software state
// - Code 001111 restores all register defaults
// - Soft reset zeroes DACs, done in 135 us
// - Monitor code takes six-bit channel selection
// - Monitor routes channel or external input
// - Monitor enable bit gates pin, else three-state
// - Selection 63 three-states monitor pin
// - Code 1100 loads 14-bit control register
`timescale 1ns/1ns
`default_nettype none
module dac_special_command_decoder #(
  parameter bit EIGHT_CHANNEL = 1'b0,
  parameter bit TWELVE_BIT = 1'b0,
  parameter int unsigned CHANNELS = 16
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  input wire logic register_select_high,
  input wire logic register_select_low,
  input wire logic [5:0] extended_command_code_bits,
  input wire logic [13:0] payload_bits,
  input wire logic clear_pin_n,
  input wire logic hw_power_down,
  output logic busy_n,
  output logic [13:0] control_config,
  output logic [13:0] clear_code,
  output logic load_clear_code,
  output logic zero_dac_registers,
  output logic reset_calibration,
  output logic power_down,
  output logic output_high_impedance,
  output logic output_load_to_ground,
  output logic [CHANNELS-1:0] monitor_channel_select,
  output logic monitor_select_ext_one,
  output logic monitor_select_ext_two,
  output logic monitor_output_pin_oe
);
  typedef struct packed {
    logic [13:0] ctrl;
    logic [13:0] clr_code;
    logic [5:0] mon_sel;
    logic soft_pd;
    logic clr_pulse;
    logic zero_pulse;
    logic [1:0] clr_pin_sync;
    logic [1:0] pd_pin_sync;
  } dec_state_t;
  dec_state_t st_r;
  dec_state_t st_nxt;
  busy_timer_if tif ();
  logic special;
  logic [3:0] command_code_bits;
  logic [5:0] mon_field;
  logic pd_eff;

  ////////////////////////////////////////////////////////////////////////
  busy_timer u_timer (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .tif(tif)
  );

  assign command_code_bits = extended_command_code_bits[3:0];
  assign special = cmd_valid && !register_select_high && !register_select_low;
  // Monitor field sits lower on the 12-bit variant
  assign mon_field = TWELVE_BIT ? payload_bits[sfr_pkg::MON_HI_12 -: 6]
                                : payload_bits[sfr_pkg::MON_HI_14 -: 6];

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt = st_r;
    st_nxt.clr_pulse = 1'b0;
    st_nxt.zero_pulse = 1'b0;
    st_nxt.clr_pin_sync = {st_r.clr_pin_sync[0], ~clear_pin_n};
    st_nxt.pd_pin_sync = {st_r.pd_pin_sync[0], hw_power_down};
    tif.load = 1'b0;
    tif.count = '0;
    // Commands are taken whatever the phase; busy only reports timing
    if (special) begin
      if (extended_command_code_bits == sfr_pkg::CMD_SOFT_RESET) begin
        st_nxt.ctrl = sfr_pkg::CTRL_RESET;
        st_nxt.clr_code = sfr_pkg::CLEAR_CODE_RESET;
        st_nxt.mon_sel = sfr_pkg::MON_SEL_RESET;
        st_nxt.soft_pd = 1'b0;
        st_nxt.zero_pulse = 1'b1;
        tif.load = 1'b1;
        tif.count = sfr_pkg::TIMER_W'(sfr_pkg::RESET_CYC);
      end else if (extended_command_code_bits[5:4] == 2'b00) begin
        unique case (command_code_bits)
          sfr_pkg::CMD_WRITE_CLEAR_CODE: st_nxt.clr_code = payload_bits;
          sfr_pkg::CMD_SOFT_CLEAR: begin
            st_nxt.clr_pulse = 1'b1;
            tif.load = 1'b1;
            tif.count = EIGHT_CHANNEL ? sfr_pkg::TIMER_W'(sfr_pkg::CLEAR_CYC_8CH)
                                      : sfr_pkg::TIMER_W'(sfr_pkg::CLEAR_CYC_16CH);
          end
          sfr_pkg::CMD_POWER_DOWN: st_nxt.soft_pd = 1'b1;
          sfr_pkg::CMD_POWER_UP: begin
            st_nxt.soft_pd = 1'b0;
            tif.load = 1'b1;
            tif.count = sfr_pkg::TIMER_W'(sfr_pkg::POWER_UP_CYC);
          end
          sfr_pkg::CMD_MONITOR: st_nxt.mon_sel = mon_field;
          sfr_pkg::CMD_CONTROL_WRITE: st_nxt.ctrl = payload_bits;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_r <= '{ctrl: sfr_pkg::CTRL_RESET, clr_code: sfr_pkg::CLEAR_CODE_RESET,
                mon_sel: sfr_pkg::MON_SEL_RESET, soft_pd: 1'b0, clr_pulse: 1'b0,
                zero_pulse: 1'b0, clr_pin_sync: 2'b00, pd_pin_sync: 2'b00};
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign busy_n = !tif.running;
  assign control_config = st_r.ctrl;
  assign clear_code = st_r.clr_code;
  assign load_clear_code = st_r.clr_pulse || st_r.clr_pin_sync[1];
  assign zero_dac_registers = st_r.zero_pulse;
  assign reset_calibration = st_r.zero_pulse;
  // Soft state drops at once on power-up; busy covers the settle
  assign pd_eff = st_r.soft_pd || st_r.pd_pin_sync[1];
  assign power_down = pd_eff;
  assign output_high_impedance = pd_eff && st_r.ctrl[sfr_pkg::PD_STATE_BIT];
  assign output_load_to_ground = pd_eff && !st_r.ctrl[sfr_pkg::PD_STATE_BIT];

  generate
    for (genvar i = 0; i < CHANNELS; i++) begin : g_mon
      assign monitor_channel_select[i] = st_r.ctrl[sfr_pkg::MON_EN_BIT]
                                         && st_r.mon_sel == 6'(i);
    end
  endgenerate
  assign monitor_select_ext_one = st_r.ctrl[sfr_pkg::MON_EN_BIT] && st_r.mon_sel == sfr_pkg::MON_EXT_ONE;
  assign monitor_select_ext_two = st_r.ctrl[sfr_pkg::MON_EN_BIT] && st_r.mon_sel == sfr_pkg::MON_EXT_TWO;
  // Undefined codes leave the pin three-stated as well
  assign monitor_output_pin_oe = st_r.ctrl[sfr_pkg::MON_EN_BIT] && st_r.mon_sel != sfr_pkg::MON_TRISTATE
                                 && ((|monitor_channel_select) || monitor_select_ext_one
                                     || monitor_select_ext_two);
endmodule
`default_nettype wire

// ### verif/dsc_assertions.sv
/* Checker for the special-command decoder ports.
   Assumes binding into the decoder top with matching port names. */
`timescale 1ns/1ns
`default_nettype none
module dsc_checker (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  input wire logic register_select_high,
  input wire logic register_select_low,
  input wire logic [5:0] extended_command_code_bits,
  input wire logic [13:0] payload_bits,
  input wire logic hw_power_down,
  input wire logic busy_n,
  input wire logic [13:0] control_config,
  input wire logic load_clear_code,
  input wire logic zero_dac_registers,
  input wire logic power_down,
  input wire logic output_high_impedance,
  input wire logic output_load_to_ground,
  input wire logic monitor_output_pin_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic sp;
  logic [3:0] op;
  // Upper code bits must be zero, as the decoder ignores other patterns
  assign sp = cmd_valid & ~register_select_high & ~register_select_low & (extended_command_code_bits[5:4] == 2'b00);
  assign op = extended_command_code_bits[3:0];
  ////////////////////////////////////////
  a_ctrl_write_load: assert property (
    sp && op == 4'hC |=> control_config == $past(payload_bits)) else $error("control write lost");
  a_ctrl_kept_still: assert property (
    !(sp && (op == 4'hC || extended_command_code_bits == 6'h0F)) |=> $stable(control_config))
    else $error("control changed");
  a_pd_output_split: assert property (
    output_high_impedance == (power_down && control_config[13])
    && output_load_to_ground == (power_down && !control_config[13])) else $error("pd state wrong");
  a_clear_starts_busy: assert property (
    sp && op == 4'h2 |=> load_clear_code && !busy_n) else $error("clear not started");
  a_pd_cmd_enter: assert property (sp && op == 4'h8 |=> power_down) else $error("no power-down");
  a_pd_pin_or: assert property (hw_power_down [*5] |-> power_down) else $error("pin ignored");
  a_pwr_up_busy: assert property (sp && op == 4'h9 |=> !busy_n) else $error("no settle");
  a_soft_reset_pulse: assert property (
    sp && extended_command_code_bits == 6'h0F |=> zero_dac_registers && control_config == 14'h2000 && !busy_n)
    else $error("soft reset wrong");
  a_mon_off_tristate: assert property (
    !control_config[9] |-> !monitor_output_pin_oe) else $error("monitor on");
  a_mon_sel_tristate: assert property (
    sp && op == 4'hA && payload_bits[13:8] == 6'h3F |=> !monitor_output_pin_oe) else $error("sel 63 driven");
  c_ctrl: cover property (sp && op == 4'hC);
  c_srst: cover property (sp && extended_command_code_bits == 6'h0F);
  c_mon: cover property (sp && op == 4'hA ##1 monitor_output_pin_oe);
endmodule
bind dac_special_command_decoder dsc_checker chk (.*);
`default_nettype wire

// ### verif/host_ctrl.sv
/* Host model issuing one decoded word per call.
   Assumes the decoder samples the word on the rising core_clk edge. */
`timescale 1ns/1ns
`default_nettype none
module host_ctrl (
  input wire logic core_clk,
  output logic cmd_valid,
  output logic register_select_high,
  output logic register_select_low,
  output logic [5:0] extended_command_code_bits,
  output logic [13:0] payload_bits
);
  initial begin
    cmd_valid = 1'b0;
    {register_select_high, register_select_low} = 2'h3;
    extended_command_code_bits = 6'h15;
    payload_bits = 14'h2AAA;
  end
  // Word scrambled after use so stale data never passes for valid
  task automatic send(input logic [1:0] sel, input logic [5:0] code, input logic [13:0] data);
    @(posedge core_clk);
    #1;
    cmd_valid = 1'b1;
    {register_select_high, register_select_low} = sel;
    extended_command_code_bits = code;
    payload_bits = data;
    @(posedge core_clk);
    #1;
    cmd_valid = 1'b0;
    {register_select_high, register_select_low} = ~sel;
    extended_command_code_bits = ~code;
    payload_bits = ~data;
  endtask
endmodule
`default_nettype wire

// ### verif/tb_top.sv
/* Self-checking bench for the special-command decoder.
   Assumes default parameters: sixteen channels, 14-bit layout. */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic core_clk, sys_rst, cmd_valid, register_select_high, register_select_low, clear_pin_n, hw_power_down;
  logic [5:0] extended_command_code_bits;
  logic [13:0] payload_bits, control_config, clear_code;
  logic busy_n, load_clear_code, zero_dac_registers, reset_calibration, power_down, output_high_impedance;
  logic output_load_to_ground, monitor_select_ext_one, monitor_select_ext_two, monitor_output_pin_oe;
  logic [15:0] monitor_channel_select;
  int n_errors = 0;
  int checks_done = 0;
  dac_special_command_decoder dut (.*);
  host_ctrl host (.*);
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wait_busy(input int exp);
    int n;
    n = 0;
    while (busy_n !== 1'b1 && n < 5000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check(n, exp);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  task automatic t_ctrl;
    logic [5:0] bad [5] = '{6'h00, 6'h03, 6'h0B, 6'h0E, 6'h1F};
    check({busy_n, monitor_output_pin_oe, control_config}, {2'h2, 14'h2000});
    host.send(2'h0, 6'h0C, 14'h1555);
    check(control_config, 14'h1555);
    host.send(2'h1, 6'h0C, 14'h0AAA);
    check(control_config, 14'h1555);
    foreach (bad[i]) begin
      host.send(2'h0, bad[i], 14'h0AAA);
      check({busy_n, power_down, control_config}, {2'h2, 14'h1555});
    end
    $display("done: control");
  endtask
  task automatic t_clear;
    host.send(2'h0, 6'h01, 14'h2A5C);
    check({clear_code, load_clear_code, busy_n}, {14'h2A5C, 2'h1});
    host.send(2'h0, 6'h02, 14'h3FFF);
    check({clear_code, load_clear_code, busy_n}, {14'h2A5C, 2'h2});
    wait_busy(sfr_pkg::CLEAR_CYC_16CH);
    clear_pin_n = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    check({load_clear_code, busy_n}, 2'h3);
    clear_pin_n = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    check(load_clear_code, 1'b0);
    $display("done: clear");
  endtask
  task automatic t_pd;
    host.send(2'h0, 6'h08, 14'h0000);
    check({power_down, output_load_to_ground, control_config}, {2'h3, 14'h1555});
    host.send(2'h0, 6'h0C, 14'h2000);
    check({output_high_impedance, output_load_to_ground}, 2'h2);
    host.send(2'h0, 6'h09, 14'h0000);
    check(power_down, 1'b0);
    wait_busy(sfr_pkg::POWER_UP_CYC);
    hw_power_down = 1'b1;
    repeat (5) @(posedge core_clk);
    #1;
    check(power_down, 1'b1);
    hw_power_down = 1'b0;
    repeat (5) @(posedge core_clk);
    #1;
    check(power_down, 1'b0);
    $display("done: power");
  endtask
  task automatic t_mon;
    host.send(2'h0, 6'h0C, 14'h2200);
    host.send(2'h0, 6'h0A, 14'h0500);
    check({monitor_channel_select, monitor_output_pin_oe}, {16'h0020, 1'b1});
    host.send(2'h0, 6'h0A, 14'h2400);
    check(monitor_select_ext_one, 1'b1);
    host.send(2'h0, 6'h0A, 14'h2500);
    check(monitor_select_ext_two, 1'b1);
    host.send(2'h0, 6'h0A, 14'h3F00);
    check(monitor_output_pin_oe, 1'b0);
    host.send(2'h0, 6'h0C, 14'h2000);
    host.send(2'h0, 6'h0A, 14'h0500);
    check(monitor_output_pin_oe, 1'b0);
    $display("done: monitor");
  endtask
  task automatic t_srst;
    host.send(2'h0, 6'h0C, 14'h1FFF);
    host.send(2'h0, 6'h08, 14'h0000);
    host.send(2'h0, 6'h0F, 14'h0000);
    check({zero_dac_registers, reset_calibration, control_config}, {2'h3, 14'h2000});
    check({clear_code, power_down, monitor_output_pin_oe}, {14'h0000, 2'h0});
    wait_busy(sfr_pkg::RESET_CYC);
    $display("done: soft reset");
  endtask
  ////////////////////////////////////////
  initial begin
    sys_rst = 1'b1;
    hw_power_down = 1'b0;
    clear_pin_n = 1'b1;
    repeat (16) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    t_ctrl;
    t_clear;
    t_pd;
    t_mon;
    t_srst;
    tally_and_finish;
  end
  // Run needs about 4150 cycles; six times that is a hang
  initial begin
    #1000000;
    n_errors++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
